// ==== inc/tpu_consts.vh ====
// constants of the timing pattern unit, with its operation summary
// Operation
// R1: four 4-bit groups run independently
// R2: sixteen output bits, each enabled separately
// R3: per-group trigger from four timer channels
// R4: non-overlap mode delays rising outputs
// R5: selected trigger also requests the dma controller
// R6: pins 0-3,4-7,8-11,12-15 form groups 0-3
// R7: low-groups next data at A5 / A7
// R8: high-groups next data at A4 / A6
// R9: port A direction, 8-bit write-only
// R10: port B direction, 8-bit write-only
// R11: software sets direction for pattern pins
// R12: enabled port A bits ignore software writes
// R13: port A value holds groups 0-1 output
// R14: reset mode F0, trigger FF, others 00
// R15: decode lower sixteen address bits
// R16: trigger copies enabled next bits only
// R17: unused split nibbles ignore writes, read 1
// R18: one transfer per trigger pulse; pulses that arrive while the queue is full merge into one pending request
`ifndef TPU_CONSTS_VH
`define TPU_CONSTS_VH

// register indices; byte address is four times the index
`define TPU_IDX_MODE    16'hFFA0
`define TPU_IDX_TSEL    16'hFFA1
`define TPU_IDX_ENB     16'hFFA2
`define TPU_IDX_ENA     16'hFFA3
`define TPU_IDX_NDB_HI  16'hFFA4
`define TPU_IDX_NDA_HI  16'hFFA5
`define TPU_IDX_NDB_LO  16'hFFA6
`define TPU_IDX_NDA_LO  16'hFFA7
`define TPU_IDX_DDRA    16'hFFD1
`define TPU_IDX_PORTA   16'hFFD3
`define TPU_IDX_DDRB    16'hFFD4
`define TPU_IDX_PORTB   16'hFFD6

// reset values
`define TPU_RST_MODE    8'hF0
`define TPU_RST_TSEL    8'hFF
`define TPU_RST_ZERO    8'h00
`define TPU_RST_ZERO16  16'h0000
`define TPU_RST_ZERO4   4'h0
`define TPU_RST_CNT     12'h000

// byte masks
`define TPU_ALL1        8'hFF
`define TPU_HI_NIB      8'hF0
`define TPU_LO_NIB      8'h0F
`define TPU_NONE        8'h00
`define TPU_NIB1        4'hF
`define TPU_MODE_RSV    4'hF

// non-overlap margin: 20 ns at 200 MHz is four clocks
`define TPU_NOVL_W      3
`define TPU_NOVL_CYC    3'h4
`define TPU_CNT_ZERO    3'h0
`define TPU_CNT_ONE     3'h1

// dma request queue
`define TPU_FIFO_W      4
`define TPU_FIFO_D      4

`endif

// ==== core/tpu_fifo.v ====
// small flip-flop fifo with valid/ready on both sides
module tpu_fifo #(
    parameter W = 4,
    parameter D = 4
) (
    input  wire         clk_i,
    input  wire         nrst_i,
    input  wire         in_valid_i,
    output wire         in_ready_o,
    input  wire [W-1:0] in_data_i,
    output wire         out_valid_o,
    input  wire         out_ready_i,
    output wire [W-1:0] out_data_o
);
    localparam AW = (D <= 2) ? 1 : (D <= 4) ? 2 : (D <= 8) ? 3 : 4;

    reg [W-1:0]  mem_ff [0:D-1];
    reg [AW-1:0] wp_ff;
    reg [AW-1:0] rp_ff;
    reg [AW:0]   cnt_ff;
    wire         push;
    wire         pop;
    integer      i;

    function [AW-1:0] bump;
        input [AW-1:0] p;
        begin
            bump = (p == D - 1) ? {AW{1'b0}} : p + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    assign in_ready_o  = (cnt_ff != D);
    assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
    assign out_data_o  = mem_ff[rp_ff];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_ff  <= {AW{1'b0}};
            rp_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
            for (i = 0; i < D; i = i + 1) begin
                mem_ff[i] <= {W{1'b0}};
            end
        end else begin
            if (push) begin
                mem_ff[wp_ff] <= in_data_i;
                wp_ff         <= bump(wp_ff);
            end
            if (pop) begin
                rp_ff <= bump(rp_ff);
            end
            if (push & ~pop) begin
                cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ==== core/tpu_trig.v ====
// compare-match edge detection and per-group trigger selection
`include "tpu_consts.vh"

module tpu_trig (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire [3:0] cmp_i,
    input  wire [7:0] sel_i,
    output wire [3:0] fire_o
);
    reg  [3:0] prev_ff;
    wire [3:0] rise;

    function pick;
        input [3:0] r;
        input [1:0] s;
        begin
            pick = r[s];
        end
    endfunction

    // one pulse per rising edge, however long the match stays high
    assign rise = cmp_i & ~prev_ff; // R18

    // two select bits per group, group 0 in the low bits
    assign fire_o[0] = pick(rise, sel_i[1:0]); // R3
    assign fire_o[1] = pick(rise, sel_i[3:2]); // R3
    assign fire_o[2] = pick(rise, sel_i[5:4]); // R3
    assign fire_o[3] = pick(rise, sel_i[7:6]); // R3

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev_ff <= `TPU_RST_ZERO4;
        end else begin
            prev_ff <= cmp_i;
        end
    end
endmodule

// ==== core/tpu_top.v ====
// timing pattern unit: registers, group update, non-overlap and dma requests
`include "tpu_consts.vh"

module tpu_top (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire [31:0] avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    input  wire [3:0]  cmp_match_i,
    input  wire [15:0] pin_i,
    output wire [15:0] pattern_pin_bus_o,
    output wire [15:0] pattern_pin_oe_o,
    output wire        dma_req_valid_o,
    output wire [3:0]  dma_req_grp_o,
    input  wire        dma_req_ready_i
);
    // software-visible registers
    reg  [7:0]  mode_ff;
    reg  [7:0]  tsel_ff;
    reg  [7:0]  ena_ff;
    reg  [7:0]  enb_ff;
    reg  [7:0]  nda_ff;
    reg  [7:0]  ndb_ff;
    reg  [7:0]  ddra_ff;
    reg  [7:0]  ddrb_ff;
    reg  [15:0] pdat_ff;

    // internal state
    reg  [15:0] hold_ff;
    reg  [11:0] cnt_ff;
    reg  [3:0]  pend_ff;
    reg         ack_ff;
    reg  [7:0]  rdata_ff;

    // next values
    reg  [7:0]  nxt_mode;
    reg  [7:0]  nxt_tsel;
    reg  [7:0]  nxt_ena;
    reg  [7:0]  nxt_enb;
    reg  [7:0]  nxt_nda;
    reg  [7:0]  nxt_ndb;
    reg  [7:0]  nxt_ddra;
    reg  [7:0]  nxt_ddrb;
    reg  [15:0] nxt_pdat;
    reg  [15:0] nxt_hold;
    reg  [11:0] nxt_cnt;
    reg  [3:0]  nxt_pend;
    reg  [7:0]  nxt_rdata;

    // combinational helpers
    reg  [3:0]  cur_nib;
    reg  [3:0]  tgt_nib;
    reg  [3:0]  en_nib;
    reg  [3:0]  nd_nib;
    reg  [2:0]  grp_cnt;
    integer     g;

    wire [15:0] idx;
    wire        req;
    wire        wr;
    wire [7:0]  wd;
    wire [3:0]  fire;
    wire        same01;
    wire        same23;
    wire [15:0] en_all;
    wire [15:0] nd_all;
    wire [3:0]  push_grp;
    wire        fifo_in_ready;

    // replace the masked bits of old by new
    function [7:0] merge;
        input [7:0] old_v;
        input [7:0] new_v;
        input [7:0] mask;
        begin
            merge = (old_v & ~mask) | (new_v & mask);
        end
    endfunction

    // read view of a next-data address
    function [7:0] nd_rd;
        input       same;
        input       hi_addr;
        input [7:0] v;
        begin
            if (hi_addr) begin
                nd_rd = same ? v : {v[7:4], `TPU_NIB1};
            end else begin
                nd_rd = same ? `TPU_ALL1 : {`TPU_NIB1, v[3:0]};
            end
        end
    endfunction

    // writable bits of a next-data address
    function [7:0] nd_wm;
        input same;
        input hi_addr;
        begin
            if (hi_addr) begin
                nd_wm = same ? `TPU_ALL1 : `TPU_HI_NIB;
            end else begin
                nd_wm = same ? `TPU_NONE : `TPU_LO_NIB;
            end
        end
    endfunction

    // port read: register for output pins, pin level for inputs
    function [7:0] port_rd;
        input [7:0] dat;
        input [7:0] ddr;
        input [7:0] pin;
        begin
            port_rd = (dat & ddr) | (pin & ~ddr);
        end
    endfunction

    // software write to a port byte: bits under pattern output keep their value
    function [7:0] port_wr;
        input [7:0] old_v;
        input [7:0] new_v;
        input [7:0] en;
        begin
            port_wr = merge(old_v, new_v, ~en);
        end
    endfunction

    // enabled bits take new_v, the others keep old_v, one group wide
    function [3:0] nib_pick;
        input [3:0] old_v;
        input [3:0] new_v;
        input [3:0] en;
        begin
            nib_pick = (old_v & ~en) | (new_v & en);
        end
    endfunction

    // two groups share a trigger when their select fields match
    function same_trig;
        input [3:0] pair;
        begin
            same_trig = (pair[1:0] == pair[3:2]);
        end
    endfunction

    // word index taken from the byte address, low sixteen bits decoded
    assign idx = avs_address_i[17:2]; // R15
    assign req = avs_read_i | avs_write_i;
    assign wd  = avs_writedata_i[7:0];

    // one wait state: data and write strobe land on the ack cycle
    assign avs_waitrequest_o = req & ~ack_ff;
    assign wr                = avs_write_i & ack_ff & avs_byteenable_i[0];
    assign avs_readdata_o    = {24'h000000, rdata_ff};

    assign same01 = same_trig(tsel_ff[3:0]);
    assign same23 = same_trig(tsel_ff[7:4]);

    // bit n of these vectors belongs to pin n
    assign en_all = {enb_ff, ena_ff}; // R2
    assign nd_all = {ndb_ff, nda_ff};

    assign pattern_pin_bus_o = pdat_ff;            // R13
    assign pattern_pin_oe_o  = {ddrb_ff, ddra_ff}; // R11

    tpu_trig u_trig (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .cmp_i  (cmp_match_i),
        .sel_i  (tsel_ff),
        .fire_o (fire)
    );

    // groups that fired now or still wait for room in the queue
    assign push_grp = pend_ff | fire; // R5

    tpu_fifo #(
        .W (`TPU_FIFO_W),
        .D (`TPU_FIFO_D)
    ) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (|push_grp),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_grp),
        .out_valid_o (dma_req_valid_o),
        .out_ready_i (dma_req_ready_i),
        .out_data_o  (dma_req_grp_o)
    );

    // register writes
    always @* begin
        nxt_mode = mode_ff;
        nxt_tsel = tsel_ff;
        nxt_ena  = ena_ff;
        nxt_enb  = enb_ff;
        nxt_nda  = nda_ff;
        nxt_ndb  = ndb_ff;
        nxt_ddra = ddra_ff;
        nxt_ddrb = ddrb_ff;
        if (wr) begin
            case (idx)
                `TPU_IDX_MODE: begin
                    nxt_mode = {`TPU_MODE_RSV, wd[3:0]};
                end
                `TPU_IDX_TSEL: begin
                    nxt_tsel = wd;
                end
                `TPU_IDX_ENA: begin
                    nxt_ena = wd;
                end
                `TPU_IDX_ENB: begin
                    nxt_enb = wd;
                end
                `TPU_IDX_NDA_HI: begin
                    nxt_nda = merge(nda_ff, wd, nd_wm(same01, 1'b1)); // R7
                end
                `TPU_IDX_NDA_LO: begin
                    nxt_nda = merge(nda_ff, wd, nd_wm(same01, 1'b0)); // R17
                end
                `TPU_IDX_NDB_HI: begin
                    nxt_ndb = merge(ndb_ff, wd, nd_wm(same23, 1'b1)); // R8
                end
                `TPU_IDX_NDB_LO: begin
                    nxt_ndb = merge(ndb_ff, wd, nd_wm(same23, 1'b0)); // R17
                end
                `TPU_IDX_DDRA: begin
                    nxt_ddra = wd; // R9
                end
                `TPU_IDX_DDRB: begin
                    nxt_ddrb = wd; // R10
                end
                default: begin
                    nxt_mode = mode_ff;
                end
            endcase
        end
    end

    // read data, sampled on the wait cycle
    always @* begin
        nxt_rdata = rdata_ff;
        if (avs_read_i & ~ack_ff) begin
            case (idx)
                `TPU_IDX_MODE:   nxt_rdata = mode_ff;
                `TPU_IDX_TSEL:   nxt_rdata = tsel_ff;
                `TPU_IDX_ENA:    nxt_rdata = ena_ff;
                `TPU_IDX_ENB:    nxt_rdata = enb_ff;
                `TPU_IDX_NDA_HI: nxt_rdata = nd_rd(same01, 1'b1, nda_ff); // R7
                `TPU_IDX_NDA_LO: nxt_rdata = nd_rd(same01, 1'b0, nda_ff); // R17
                `TPU_IDX_NDB_HI: nxt_rdata = nd_rd(same23, 1'b1, ndb_ff); // R8
                `TPU_IDX_NDB_LO: nxt_rdata = nd_rd(same23, 1'b0, ndb_ff); // R17
                `TPU_IDX_PORTA:  nxt_rdata = port_rd(pdat_ff[7:0], ddra_ff, pin_i[7:0]);
                `TPU_IDX_PORTB:  nxt_rdata = port_rd(pdat_ff[15:8], ddrb_ff, pin_i[15:8]);
                // direction registers are write-only and read as zero
                default:         nxt_rdata = `TPU_NONE;
            endcase
        end
    end

    // port data: software writes, then group transfers
    always @* begin
        nxt_pdat = pdat_ff;
        nxt_hold = hold_ff;
        nxt_cnt  = cnt_ff;
        cur_nib  = `TPU_RST_ZERO4;
        tgt_nib  = `TPU_RST_ZERO4;
        en_nib   = `TPU_RST_ZERO4;
        nd_nib   = `TPU_RST_ZERO4;
        grp_cnt  = `TPU_CNT_ZERO;
        if (wr && idx == `TPU_IDX_PORTA) begin
            nxt_pdat[7:0] = port_wr(pdat_ff[7:0], wd, ena_ff); // R12
        end
        if (wr && idx == `TPU_IDX_PORTB) begin
            nxt_pdat[15:8] = port_wr(pdat_ff[15:8], wd, enb_ff); // R12
        end
        // each group owns pins 4g to 4g+3 and runs on its own trigger
        for (g = 0; g < 4; g = g + 1) begin // R1
            cur_nib = nxt_pdat[g*4 +: 4]; // R6
            en_nib  = en_all[g*4 +: 4];
            nd_nib  = nd_all[g*4 +: 4];
            grp_cnt = cnt_ff[g*3 +: 3];
            tgt_nib = nib_pick(cur_nib, nd_nib, en_nib); // R16
            if (fire[g]) begin
                if (mode_ff[g]) begin
                    // falling bits now, rising bits after the margin
                    nxt_pdat[g*4 +: 4] = cur_nib & tgt_nib; // R4
                    nxt_hold[g*4 +: 4] = tgt_nib;
                    nxt_cnt[g*3 +: 3]  = `TPU_NOVL_CYC; // R4
                end else begin
                    nxt_pdat[g*4 +: 4] = tgt_nib; // R16
                    nxt_cnt[g*3 +: 3]  = `TPU_CNT_ZERO;
                end
            end else if (grp_cnt != `TPU_CNT_ZERO) begin
                nxt_cnt[g*3 +: 3] = grp_cnt - `TPU_CNT_ONE;
                if (grp_cnt == `TPU_CNT_ONE) begin
                    nxt_pdat[g*4 +: 4] = nib_pick(cur_nib, hold_ff[g*4 +: 4], en_nib); // R4
                end
            end
        end
    end

    // a full queue keeps the requests pending rather than dropping them
    always @* begin
        if (fifo_in_ready) begin
            nxt_pend = `TPU_RST_ZERO4;
        end else begin
            nxt_pend = push_grp; // R5
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_ff  <= `TPU_RST_MODE; // R14
            tsel_ff  <= `TPU_RST_TSEL; // R14
            ena_ff   <= `TPU_RST_ZERO; // R14
            enb_ff   <= `TPU_RST_ZERO;
            nda_ff   <= `TPU_RST_ZERO;
            ndb_ff   <= `TPU_RST_ZERO;
            ddra_ff  <= `TPU_RST_ZERO;
            ddrb_ff  <= `TPU_RST_ZERO;
            pdat_ff  <= `TPU_RST_ZERO16;
            hold_ff  <= `TPU_RST_ZERO16;
            cnt_ff   <= `TPU_RST_CNT;
            pend_ff  <= `TPU_RST_ZERO4;
            ack_ff   <= 1'b0;
            rdata_ff <= `TPU_RST_ZERO;
        end else begin
            mode_ff  <= nxt_mode;
            tsel_ff  <= nxt_tsel;
            ena_ff   <= nxt_ena;
            enb_ff   <= nxt_enb;
            nda_ff   <= nxt_nda;
            ndb_ff   <= nxt_ndb;
            ddra_ff  <= nxt_ddra;
            ddrb_ff  <= nxt_ddrb;
            pdat_ff  <= nxt_pdat;
            hold_ff  <= nxt_hold;
            cnt_ff   <= nxt_cnt;
            pend_ff  <= nxt_pend;
            ack_ff   <= req & ~ack_ff;
            rdata_ff <= nxt_rdata;
        end
    end
endmodule

// ==== test/tpu_assertions.sv ====
// port-level checker for the pattern unit
module tpu_checker (
    input logic        clk_i,
    input logic        nrst_i,
    input logic [31:0] avs_address_i,
    input logic        avs_read_i,
    input logic        avs_write_i,
    input logic [31:0] avs_writedata_i,
    input logic [3:0]  avs_byteenable_i,
    input logic [31:0] avs_readdata_o,
    input logic        avs_waitrequest_o,
    input logic [3:0]  cmp_match_i,
    input logic [15:0] pin_i,
    input logic [15:0] pattern_pin_bus_o,
    input logic [15:0] pattern_pin_oe_o,
    input logic        dma_req_valid_o,
    input logic [3:0]  dma_req_grp_o,
    input logic        dma_req_ready_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] prev_ff;
    logic [2:0] quiet_ff;
    wire  [3:0] rise  = cmp_match_i & ~prev_ff;
    wire        req   = avs_read_i | avs_write_i;
    wire        wr_ok = avs_write_i & ~avs_waitrequest_o;
    // cycles since the last trigger edge, saturating
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev_ff  <= 4'h0;
            quiet_ff <= 3'h0;
        end else begin
            prev_ff  <= cmp_match_i;
            quiet_ff <= (rise != 4'h0) ? 3'h0 : (quiet_ff == 3'h7) ? 3'h7 : quiet_ff + 3'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence held_wait;
        req && avs_waitrequest_o;
    endsequence
    sequence no_rise;
        rise == 4'h0;
    endsequence
    first_wait_a: assert property ($rose(req) |-> avs_waitrequest_o) else $error("no wait state");
    ack_next_a: assert property (held_wait |=> !req || !avs_waitrequest_o) else $error("late ack");
    read_upper_a: assert property (avs_readdata_o[31:8] == 24'h0) else $error("upper read bits");
    read_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("read data moved");
    dir_hold_a: assert property (!wr_ok |=> $stable(pattern_pin_oe_o)) else $error("enable moved");
    pin_hold_a: assert property (no_rise and quiet_ff >= 3'h5 && !wr_ok |=> $stable(pattern_pin_bus_o))
        else $error("pins moved");
    dma_cause_a: assert property (!dma_req_valid_o && rise == 4'h0 && $past(rise) == 4'h0 |=> !dma_req_valid_o)
        else $error("dma without trigger");
    grp_nonzero_a: assert property (dma_req_valid_o |-> dma_req_grp_o != 4'h0) else $error("empty mask");
    dma_hold_a: assert property (dma_req_valid_o && !dma_req_ready_i |=> dma_req_valid_o && $stable(dma_req_grp_o))
        else $error("dma head moved");
endmodule

bind tpu_top tpu_checker i_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .cmp_match_i(cmp_match_i),
    .pin_i(pin_i), .pattern_pin_bus_o(pattern_pin_bus_o), .pattern_pin_oe_o(pattern_pin_oe_o),
    .dma_req_valid_o(dma_req_valid_o), .dma_req_grp_o(dma_req_grp_o), .dma_req_ready_i(dma_req_ready_i)
);

// ==== test/tpu_partner.sv ====
// timer compare-match source and dma controller stand-in
module tpu_partner (
    input  logic       clk_i,
    input  logic       stall_i,
    input  logic       dma_valid_i,
    input  logic [3:0] dma_grp_i,
    output logic       dma_ready_o,
    output logic [3:0] cmp_match_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] got[$];
    initial cmp_match_o = 4'h0;
    assign dma_ready_o = ~stall_i;
    // each accepted word is recorded in got, in order of acceptance
    always @(posedge clk_i) begin
        if (dma_valid_i && dma_ready_o) begin
            got.push_back(dma_grp_i);
        end
    end
    task pulse(input int ch, input int len);
        @(posedge clk_i);
        cmp_match_o[ch] <= 1'b1;
        repeat (len) @(posedge clk_i);
        cmp_match_o[ch] <= 1'b0;
    endtask
endmodule

// ==== test/tpu_tb.sv ====
// self-checking bench for the pattern unit
`include "tpu_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [31:0] avs_address_i = 32'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [3:0]  cmp_match_i;
    logic [15:0] pattern_pin_bus_o;
    logic [15:0] pattern_pin_oe_o;
    logic        dma_req_valid_o;
    logic [3:0]  dma_req_grp_o;
    logic        dma_req_ready_i;
    logic        stall = 1'b0;
    logic [13:0] hi_q = 14'h0;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          dn = 0;
    tpu_top i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .cmp_match_i(cmp_match_i), .pin_i(16'h5A3C), .pattern_pin_bus_o(pattern_pin_bus_o),
        .pattern_pin_oe_o(pattern_pin_oe_o), .dma_req_valid_o(dma_req_valid_o),
        .dma_req_grp_o(dma_req_grp_o), .dma_req_ready_i(dma_req_ready_i));
    tpu_partner i_partner (
        .clk_i(clk_i), .stall_i(stall), .dma_valid_i(dma_req_valid_o), .dma_grp_i(dma_req_grp_o),
        .dma_ready_o(dma_req_ready_i), .cmp_match_o(cmp_match_i));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_out(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        avs_address_i   <= {hi_q, idx, 2'h0};
        avs_writedata_i <= {24'h0, d};
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask
    task wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task rd(input logic [15:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h0, q);
        chk_reg(q, exp);
    endtask
    task pins(input logic [15:0] exp);
        #1;
        chk_out(pattern_pin_bus_o, exp);
    endtask
    task chk_dma(input logic [3:0] exp);
        repeat (3) @(posedge clk_i);
        #1;
        chk_out(16'(i_partner.got.size()), 16'(dn + 1));
        chk_out({12'h0, i_partner.got[dn]}, {12'h0, exp});
        dn++;
    endtask
    task t_reset;
        rd(`TPU_IDX_MODE, 8'hF0);
        rd(`TPU_IDX_TSEL, 8'hFF);
        rd(`TPU_IDX_ENB, 8'h00);
        rd(`TPU_IDX_ENA, 8'h00);
        rd(`TPU_IDX_NDB_HI, 8'h00);
        rd(`TPU_IDX_NDA_HI, 8'h00);
        rd(`TPU_IDX_NDA_LO, 8'hFF);
        rd(`TPU_IDX_PORTA, 8'h3C);
        rd(16'h1234, 8'h00);
        pins(16'h0000);
    endtask
    task t_dir;
        hi_q = 14'h2A5;
        wr(`TPU_IDX_DDRA, 8'hFF);
        wr(`TPU_IDX_DDRB, 8'hFF);
        hi_q = 14'h0;
        rd(`TPU_IDX_DDRA, 8'h00);
        rd(`TPU_IDX_DDRB, 8'h00);
        #1 chk_out(pattern_pin_oe_o, 16'hFFFF);
    endtask
    task t_same;
        wr(`TPU_IDX_TSEL, 8'h00);
        wr(`TPU_IDX_ENA, 8'hFF);
        wr(`TPU_IDX_ENB, 8'h0F);
        wr(`TPU_IDX_NDA_HI, 8'hA5);
        wr(`TPU_IDX_NDB_HI, 8'h3C);
        rd(`TPU_IDX_NDA_HI, 8'hA5);
        rd(`TPU_IDX_NDB_LO, 8'hFF);
        i_partner.pulse(0, 1);
        pins(16'h0CA5);
        chk_dma(4'hF);
        wr(`TPU_IDX_PORTA, 8'h00);
        wr(`TPU_IDX_PORTB, 8'hF0);
        rd(`TPU_IDX_PORTA, 8'hA5);
        pins(16'hFCA5);
    endtask
    task t_split;
        wr(`TPU_IDX_TSEL, 8'hD9);
        wr(`TPU_IDX_NDA_HI, 8'h70);
        wr(`TPU_IDX_NDA_LO, 8'h36);
        wr(`TPU_IDX_NDB_LO, 8'h01);
        wr(`TPU_IDX_NDB_HI, 8'h90);
        rd(`TPU_IDX_NDA_HI, 8'h7F);
        rd(`TPU_IDX_NDA_LO, 8'hF6);
        rd(`TPU_IDX_NDB_LO, 8'hF1);
        i_partner.pulse(1, 1);
        pins(16'hF1A6);
        chk_dma(4'h5);
        i_partner.pulse(2, 1);
        pins(16'hF176);
        chk_dma(4'h2);
        i_partner.pulse(3, 1);
        pins(16'hF176);
        chk_dma(4'h8);
        i_partner.pulse(1, 5);
        chk_dma(4'h5);
    endtask
    task t_fifo;
        logic [3:0] exp_q [5];
        exp_q = '{4'h5, 4'h2, 4'h5, 4'h2, 4'h7};
        @(posedge clk_i);
        stall <= 1'b1;
        for (int i = 0; i < 6; i++) i_partner.pulse(1 + i % 2, 1);
        repeat (3) @(posedge clk_i);
        stall <= 1'b0;
        repeat (15) @(posedge clk_i);
        #1;
        chk_out(16'(i_partner.got.size()), 16'(dn + 5));
        for (int i = 0; i < 5; i++) chk_out({12'h0, i_partner.got[dn + i]}, {12'h0, exp_q[i]});
        dn += 5;
    endtask
    task t_novl;
        wr(`TPU_IDX_MODE, 8'h01);
        rd(`TPU_IDX_MODE, 8'hF1);
        wr(`TPU_IDX_NDA_LO, 8'h09);
        i_partner.pulse(1, 1);
        pins(16'hF170);
        repeat (4) @(posedge clk_i);
        pins(16'hF179);
        chk_dma(4'h5);
    endtask
    task conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_dir();
        t_same();
        t_split();
        t_fifo();
        t_novl();
        conclude();
    end
endmodule
